// File: hdl/prs_delay_timer.sv
/*
  Start-up delay timer: counts while armed, flags done after the target.
  Assumes arm_i is a level that drops to restart the count.
*/
`timescale 1ns/100ps
module prs_delay_timer #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic             arm_i,
  input  wire logic [CNT_W-1:0] target_i,
  output logic                  done_o
);

  logic [CNT_W-1:0] cnt;

  // Count from the arming edge; losing the arm clears everything.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt    <= '0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (!arm_i) begin
        cnt    <= '0;
        done_o <= 1'b0;
      end else if (cnt >= target_i) begin
        done_o <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule : prs_delay_timer

// File: hdl/prs_pulse_gen.sv
/*
  Fixed-rate pulse generator with a programmable high time.
  Assumes PERIOD is above HIGH and both are at least one.
*/
`timescale 1ns/100ps
module prs_pulse_gen #(
  parameter int unsigned CNT_W  = 32,
  parameter int unsigned PERIOD = 2,
  parameter int unsigned HIGH   = 1
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic en_i,
  output logic      pulse_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] hi_run;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Free-running phase counter, held at zero while disabled.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt     <= '0;
      pulse_o <= 1'b0;
    end else if (ce_i) begin
      if (!en_i) begin
        cnt     <= '0;
        pulse_o <= 1'b0;
      end else begin
        cnt     <= (cnt >= CNT_W'(PERIOD - 1)) ? '0 : cnt + 1'b1;
        pulse_o <= (cnt < CNT_W'(HIGH));
      end
    end
  end

  // Length of the current high run, read only by the checks.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hi_run <= '0;
    end else if (ce_i) begin
      hi_run <= pulse_o ? hi_run + 1'b1 : '0;
    end
  end

  AST_PULSE_HIGH_LEN: assert property (
    pulse_o |-> hi_run < CNT_W'(HIGH))
    else $error("Pulse high longer than its duty time.");

  AST_PULSE_OFF: assert property (
    ce_i && !en_i |=> !pulse_o)
    else $error("Pulse output high while disabled.");

endmodule : prs_pulse_gen

// File: hdl/prs_sequencer.sv
/*
  Power rail sequencer: rail chain, start and stop control, gated
  reset output, pulse outputs and I2C-written buck settings.
  Assumes host pins and power-good inputs are synchronous to core_clk_i
  and that I2C register decode lives outside and drives host_i.
*/
`timescale 1ns/100ps
module prs_sequencer #(
  parameter prs_pkg::prs_profile_t PROFILE = prs_pkg::PRS_PROF_EN,
  parameter int unsigned CNT_W           = 32,
  parameter int unsigned CHAIN_SHORT_CYC = prs_pkg::CHAIN_SHORT_CYC,
  parameter int unsigned CHAIN_LONG_CYC  = prs_pkg::CHAIN_LONG_CYC,
  parameter int unsigned RST_SHORT_CYC   = prs_pkg::RST_SHORT_CYC,
  parameter int unsigned RST_LONG_CYC    = prs_pkg::RST_LONG_CYC,
  parameter int unsigned FAST_PERIOD_CYC = prs_pkg::FAST_PERIOD_CYC,
  parameter int unsigned FAST_HIGH_CYC   = prs_pkg::FAST_HIGH_CYC,
  parameter int unsigned SLOW_PERIOD_CYC = prs_pkg::SLOW_PERIOD_CYC,
  parameter int unsigned SLOW_HIGH_CYC   = prs_pkg::SLOW_HIGH_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               ce_i,
  input  wire prs_pkg::prs_pins_t pins_i,
  input  wire prs_pkg::prs_host_t host_i,
  input  wire logic [12:0]        rail_pgood_i,
  output logic [12:0]             rail_en_o,
  output logic                    system_reset_out_n_o,
  output logic                    pulse_out_3_o,
  output logic [2:0]              slow_pulse_outs_o,
  output logic [3:0]              dynamic_voltage_scaling_o,
  output logic [3:0]              forced_pwm_o
);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ARMED,
    ST_PB_WAIT,
    ST_RUN
  } prs_state_t;

  localparam bit IS_A = (PROFILE == prs_pkg::PRS_PROF_EN);
  localparam bit IS_B = (PROFILE == prs_pkg::PRS_PROF_TRIG);
  localparam bit IS_C = (PROFILE == prs_pkg::PRS_PROF_PB);
  localparam logic [12:0] I2C_MASK = IS_A ? prs_pkg::I2C_MASK_A
                                          : prs_pkg::I2C_MASK_BC;
  localparam logic [12:0] KEEP = IS_A ? prs_pkg::KEEP_A : prs_pkg::KEEP_BC;
  localparam int unsigned GATE = IS_A ? prs_pkg::GATE_A : prs_pkg::GATE_BC;
  localparam logic [CNT_W-1:0] RST_CYC = IS_A ? CNT_W'(RST_SHORT_CYC)
                                              : CNT_W'(RST_LONG_CYC);
  localparam logic [3:0] PWM_RST = IS_C ? prs_pkg::PWM_FORCED
                                        : prs_pkg::PWM_SAVE;

  prs_state_t  state;
  prs_state_t  next_state;
  logic        en_q;
  logic        trig_q;
  logic        en_rise;
  logic        trig_rise;
  logic        resume_lock;
  logic        live;
  logic        next_live;
  logic [12:0] chain_arm;
  logic [12:0] chain_done;
  logic [12:0] next_rails;
  logic        gate_ok;
  logic        rst_done;
  logic        fast_pulse;
  logic        slow_pulse;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Edge detection on the enable and trigger pins.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      en_q   <= 1'b0;
      trig_q <= 1'b0;
    end else if (ce_i) begin
      en_q   <= pins_i.sequence_enable_in;
      trig_q <= pins_i.sequence_trigger_pin;
    end
  end

  assign en_rise   = pins_i.sequence_enable_in && !en_q;
  assign trig_rise = pins_i.sequence_trigger_pin && !trig_q;
  assign live      = (state == ST_RUN) || (state == ST_PB_WAIT);
  assign next_live = (next_state == ST_RUN) || (next_state == ST_PB_WAIT);

  // Start and stop decisions for the selected profile.
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (IS_A) begin
          if (en_rise && !resume_lock) begin
            next_state = ST_RUN;
          end
        end else if (IS_B) begin
          if (pins_i.sequence_enable_in && pins_i.power_hold_in) begin
            next_state = ST_ARMED;
          end
        end else begin
          if (!pins_i.push_button_in_n) begin
            next_state = ST_PB_WAIT;
          end else if (en_rise) begin
            next_state = ST_RUN;
          end
        end
      end
      ST_ARMED: begin
        if (!pins_i.sequence_enable_in || !pins_i.power_hold_in) begin
          next_state = ST_OFF;
        end else if (trig_rise) begin
          next_state = ST_RUN;
        end
      end
      ST_PB_WAIT: begin
        if (pins_i.sequence_enable_in && pins_i.power_hold_in) begin
          next_state = ST_RUN;
        end else if (pins_i.push_button_in_n) begin
          next_state = ST_OFF;
        end
      end
      ST_RUN: begin
        if (IS_C) begin
          if ((!pins_i.sequence_enable_in && !pins_i.power_hold_in)
              || host_i.off_cmd) begin
            next_state = ST_OFF;
          end
        end else if (!pins_i.sequence_enable_in) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state <= ST_OFF;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Profile A refuses a restart if enable fell without resume enabled.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      resume_lock <= 1'b0;
    end else if (ce_i && IS_A && state == ST_RUN && next_state == ST_OFF
                 && !host_i.shutdown_resume_enable) begin
      resume_lock <= 1'b1;
    end
  end

  // One start-up timer per rail, armed once its source counts as up.
  for (genvar i = 0; i < prs_pkg::RAIL_W; i++) begin : g_rail
    localparam logic [3:0] SRC = prs_pkg::prs_src(PROFILE, i);
    localparam logic [1:0] DLY = prs_pkg::prs_dly(PROFILE, i);
    localparam logic [CNT_W-1:0] TGT =
      (DLY == prs_pkg::DLY_SHORT) ? CNT_W'(CHAIN_SHORT_CYC) :
      (DLY == prs_pkg::DLY_LONG)  ? CNT_W'(CHAIN_LONG_CYC)  : '0;
    logic src_ok;

    if (SRC == prs_pkg::SRC_START) begin : g_start
      assign src_ok = 1'b1;
    end else if (SRC == prs_pkg::SRC_NONE) begin : g_none
      assign src_ok = 1'b0;
    end else begin : g_dep
      assign src_ok = rail_en_o[SRC] && rail_pgood_i[SRC];
    end

    assign chain_arm[i] = live && src_ok;

    prs_delay_timer #(
      .CNT_W (CNT_W)
    ) u_timer (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (ce_i),
      .arm_i      (chain_arm[i]),
      .target_i   (TGT),
      .done_o     (chain_done[i])
    );
  end

  // Next rail enables: chain, I2C rails, shutdown masking.
  always_comb begin
    next_rails = rail_en_o;
    if (!next_live) begin
      next_rails = rail_en_o & KEEP;
    end else begin
      next_rails = rail_en_o | (chain_done & chain_arm);
      if (next_state == ST_RUN) begin
        next_rails = (next_rails & ~I2C_MASK)
                     | (host_i.rail_on & I2C_MASK);
      end
    end
    if (IS_A && pins_i.power_hold_in) begin
      next_rails[prs_pkg::HOLD_RAIL_A] = 1'b1;
    end
    next_rails[prs_pkg::AON_RAIL] = 1'b1;
  end

  // Rail enable register.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rail_en_o <= prs_pkg::RAIL_RESET;
    end else if (ce_i) begin
      rail_en_o <= next_rails;
    end
  end

  // Reset output is gated by one rail and delayed after it is good.
  assign gate_ok = rail_en_o[GATE] && rail_pgood_i[GATE];

  prs_delay_timer #(
    .CNT_W (CNT_W)
  ) u_rst_timer (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .arm_i      (gate_ok),
    .target_i   (RST_CYC),
    .done_o     (rst_done)
  );

  // Registered reset release.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      system_reset_out_n_o <= 1'b0;
    end else if (ce_i) begin
      system_reset_out_n_o <= rst_done && gate_ok;
    end
  end

  // Pulse generators, enabled only from I2C.
  prs_pulse_gen #(
    .CNT_W  (CNT_W),
    .PERIOD (FAST_PERIOD_CYC),
    .HIGH   (FAST_HIGH_CYC)
  ) u_fast (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .en_i       (host_i.pulse_en[0]),
    .pulse_o    (fast_pulse)
  );

  prs_pulse_gen #(
    .CNT_W  (CNT_W),
    .PERIOD (SLOW_PERIOD_CYC),
    .HIGH   (SLOW_HIGH_CYC)
  ) u_slow (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .en_i       (|host_i.pulse_en[3:1]),
    .pulse_o    (slow_pulse)
  );

  // Output stage of the pulse pins.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pulse_out_3_o     <= 1'b0;
      slow_pulse_outs_o <= 3'h0;
    end else if (ce_i) begin
      pulse_out_3_o     <= fast_pulse && host_i.pulse_en[0];
      slow_pulse_outs_o <= {3{slow_pulse}} & host_i.pulse_en[3:1];
    end
  end

  // Buck voltage select and mode, changed only by I2C writes.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dynamic_voltage_scaling_o <= prs_pkg::VSEL_RESET;
      forced_pwm_o              <= PWM_RST;
    end else if (ce_i) begin
      if (host_i.vsel_we) begin
        dynamic_voltage_scaling_o <= host_i.vsel;
      end
      if (host_i.pwm_we) begin
        forced_pwm_o <= host_i.pwm;
      end
    end
  end

  AST_A_ENABLE_ON: assert property (
    IS_A && ce_i && state == ST_OFF && next_state == ST_RUN
    ##1 (ce_i && pins_i.sequence_enable_in)[*3]
    |-> rail_en_o[4:0] == 5'h1F)
    else $error("Rails 1-5 not on three cycles after enable rise.");

  AST_A_ENABLE_OFF: assert property (
    IS_A && ce_i && state == ST_RUN && !pins_i.sequence_enable_in
    |=> rail_en_o[10:0] == 11'h000)
    else $error("Rails 1-11 still on after enable fell.");

  AST_B_ARM_ONLY: assert property (
    IS_B && state == ST_ARMED |-> rail_en_o[11:0] == 12'h000)
    else $error("Rail on while only armed.");

  AST_B_ENABLE_OFF: assert property (
    IS_B && ce_i && state != ST_OFF && !pins_i.sequence_enable_in
    |=> rail_en_o == prs_pkg::RAIL_RESET)
    else $error("Rails other than 13 on after enable fell.");

  AST_TRIG_FALL_KEEP: assert property (
    !IS_A && ce_i && state == ST_RUN && next_state == ST_RUN
    && rail_en_o[1] && !pins_i.sequence_trigger_pin |=> rail_en_o[1])
    else $error("Chained rail dropped while running.");

  AST_PB_EARLY_RELEASE: assert property (
    IS_C && ce_i && state == ST_PB_WAIT && pins_i.push_button_in_n
    && !pins_i.power_hold_in
    |=> state == ST_OFF && rail_en_o[11:0] == 12'h000)
    else $error("Early button release did not shut down.");

  AST_CHAIN_SOURCE_GOOD: assert property (
    !IS_A && $rose(rail_en_o[6])
    |-> $past(rail_en_o[1] && rail_pgood_i[1]))
    else $error("Rail 7 rose before rail 2 was good.");

  AST_RESET_GATED: assert property (
    $rose(system_reset_out_n_o) |-> $past(gate_ok && rst_done))
    else $error("Reset released without its gate rail good.");

  AST_C_I2C_RAILS_OFF: assert property (
    IS_C && state == ST_PB_WAIT |-> (rail_en_o & I2C_MASK) == 13'h0000)
    else $error("I2C rail on during push-button start.");

  AST_I2C_RAILS_FOLLOW: assert property (
    !IS_A && ce_i && next_state == ST_RUN
    |=> (rail_en_o & I2C_MASK) == ($past(host_i.rail_on) & I2C_MASK))
    else $error("I2C rail does not follow its host setting.");

  AST_RESET_HELD: assert property (
    ce_i && !gate_ok |=> !system_reset_out_n_o)
    else $error("Reset released while its gate rail is down.");

endmodule : prs_sequencer

// File: inc/prs_pkg.sv
/*
  Shared constants, tables and carrier types of the power rail sequencer.
  Assumes a 100 MHz core clock and one fixed factory profile per build.
*/
// Function
// - Profile A: I2C rails 6-11; enable low drops all but 12/13
// - Profile A: rising enable turns on rails 1-5
// - Profile A: reset released 2ms after rail 12 good
// - Profile A: push-button input has no function
// - Pulse outputs off at reset; pulse 3 256Hz 50%
// - Slow pulse outputs 0.25Hz with 6.25% high time
// - Profile B: trigger starts the fixed rail chain
// - Profile B: enable and hold only arm the sequencer
// - Profile B: I2C rails 4,5,6,12 only while enabled
// - Profile B: enable low drops all but rail 13
// - Profiles B/C: reset released 40ms after rail 9 good
// - Falling trigger never switches chained rails off
// - Profile C: push-button low begins start-up
// - Button released before hold high shuts everything down
// - Profile C: enable rise with button high starts
// - Profile C: rails 4,5,6,12 off until I2C
// - Profile C: off on enable and hold low, or I2C
// - Voltage changes only through I2C writes
// - Profile C: bucks reset into forced fixed frequency
package prs_pkg;

  // Clock rate and the printed times.
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CHAIN_SHORT_US = 500;
  localparam int unsigned CHAIN_LONG_US  = 1000;
  localparam int unsigned RST_SHORT_MS   = 2;
  localparam int unsigned RST_LONG_MS    = 40;
  localparam int unsigned FAST_PULSE_HZ  = 256;
  localparam int unsigned FAST_DUTY_PCT  = 50;
  localparam int unsigned SLOW_PERIOD_S  = 4;
  localparam int unsigned SLOW_DUTY_PPM  = 62_500;

  // Cycle counts derived from the times above.
  localparam int unsigned CHAIN_SHORT_CYC = CLK_HZ / 1_000_000 * CHAIN_SHORT_US;
  localparam int unsigned CHAIN_LONG_CYC  = CLK_HZ / 1_000_000 * CHAIN_LONG_US;
  localparam int unsigned RST_SHORT_CYC   = CLK_HZ / 1000 * RST_SHORT_MS;
  localparam int unsigned RST_LONG_CYC    = CLK_HZ / 1000 * RST_LONG_MS;
  localparam int unsigned FAST_PERIOD_CYC = CLK_HZ / FAST_PULSE_HZ;
  localparam int unsigned FAST_HIGH_CYC   = FAST_PERIOD_CYC * FAST_DUTY_PCT / 100;
  localparam int unsigned SLOW_PERIOD_CYC = CLK_HZ * SLOW_PERIOD_S;
  localparam int unsigned SLOW_HIGH_CYC   = CLK_HZ / 1_000_000 * SLOW_DUTY_PPM
                                            * SLOW_PERIOD_S;

  // Rail count, source codes and delay classes.
  localparam int unsigned RAIL_W    = 13;
  localparam logic [3:0]  SRC_START = 4'hE;
  localparam logic [3:0]  SRC_NONE  = 4'hF;
  localparam logic [1:0]  DLY_ZERO  = 2'h0;
  localparam logic [1:0]  DLY_SHORT = 2'h1;
  localparam logic [1:0]  DLY_LONG  = 2'h2;

  // Per-rail trigger source and delay class, index 12 first.
  localparam logic [12:0][3:0] SRC_A  = {4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF,
    4'hF, 4'hF, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE};
  localparam logic [12:0][3:0] SRC_BC = {4'hF, 4'hF, 4'h0, 4'h7, 4'h7, 4'h2,
    4'h1, 4'hF, 4'hF, 4'hF, 4'hA, 4'hE, 4'h6};
  localparam logic [12:0][1:0] DLY_BC = {2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1,
    2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0};

  // Rail masks and reset values.
  localparam logic [12:0] I2C_MASK_A  = 13'h07E0;
  localparam logic [12:0] I2C_MASK_BC = 13'h0838;
  localparam logic [12:0] KEEP_A      = 13'h1800;
  localparam logic [12:0] KEEP_BC     = 13'h1000;
  localparam logic [12:0] RAIL_RESET  = 13'h1000;
  localparam int unsigned GATE_A      = 11;
  localparam int unsigned GATE_BC     = 8;
  localparam int unsigned HOLD_RAIL_A = 11;
  localparam int unsigned AON_RAIL    = 12;
  localparam logic [3:0]  PWM_FORCED  = 4'hF;
  localparam logic [3:0]  PWM_SAVE    = 4'h0;
  localparam logic [3:0]  VSEL_RESET  = 4'h0;

  typedef enum logic [1:0] {
    PRS_PROF_EN,
    PRS_PROF_TRIG,
    PRS_PROF_PB
  } prs_profile_t;

  // Host pins.
  typedef struct packed {
    logic sequence_enable_in;
    logic power_hold_in;
    logic sequence_trigger_pin;
    logic push_button_in_n;
  } prs_pins_t;

  // Decoded I2C register controls.
  typedef struct packed {
    logic [12:0] rail_on;
    logic        off_cmd;
    logic        shutdown_resume_enable;
    logic [3:0]  pulse_en;
    logic        vsel_we;
    logic [3:0]  vsel;
    logic        pwm_we;
    logic [3:0]  pwm;
  } prs_host_t;

  function automatic logic [3:0] prs_src(prs_profile_t p, int unsigned i);
    prs_src = (p == PRS_PROF_EN) ? SRC_A[i] : SRC_BC[i];
  endfunction : prs_src

  function automatic logic [1:0] prs_dly(prs_profile_t p, int unsigned i);
    prs_dly = (p == PRS_PROF_EN) ? DLY_ZERO : DLY_BC[i];
  endfunction : prs_dly

endpackage : prs_pkg

// File: verification/prs_rail_model.sv
/*
  Power stage model: an enabled rail reports power-good after a
  selectable number of cycles and loses it as soon as it is disabled.
  Assumes rail enables are registered on core_clk_i.
*/
`timescale 1ns/100ps
module prs_rail_model (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [1:0]  lag_i,
  input  wire logic [12:0] rail_en_i,
  output logic [12:0]      rail_pgood_o
);
  logic [3:0][12:0] ramp;

  // A rail ramps for lag_i+1 cycles; a dropped enable restarts it.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ramp <= '0;
    end else begin
      ramp <= {ramp[2:0] & {3{rail_en_i}}, rail_en_i};
    end
  end

  // Good is reported only while the rail is still enabled.
  assign rail_pgood_o = ramp[lag_i] & rail_en_i;
endmodule : prs_rail_model

// File: verification/prs_sequencer_test.sv
/*
  Self-checking bench of the sequencer in all three profiles, the
  trigger profile checked edge by edge.
  Assumes the power stage model answers each enabled rail.
*/
`timescale 1ns/100ps
module prs_sequencer_test;
  localparam int SH = 5;
  localparam int LG = 10;
  localparam int RL = 20;
  localparam int ORD [8] = '{1, 6, 0, 10, 2, 7, 9, 8};
  localparam int SRC [8] = '{0, 0, 1, 2, 3, 4, 5, 5};
  logic               core_clk_i = 1'b0;
  logic               sys_rst_i  = 1'b1;
  logic [1:0]         lag        = 2'h0;
  prs_pkg::prs_pins_t pins       = 4'h1;
  prs_pkg::prs_host_t host       = '0;
  logic [12:0]        pgood;
  logic [12:0]        rail_en;
  logic [12:0]        exp_m;
  logic [12:0]        v;
  logic [3:0]         v4;
  logic               rst_n;
  logic               p3;
  logic [2:0]         slow;
  logic [3:0]         dynamic_voltage_scaling;
  logic [3:0]         fpwm;
  logic               ce         = 1'b1;
  logic [12:0]        rail_a;
  logic [12:0]        rail_c;
  logic [12:0]        pg_c;
  logic               rst_a;
  logic [3:0]         fpwm_c;
  int                 error_cnt = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  int                 base;
  int                 n;
  int                 h3;
  int                 hs;
  int                 t [13];

  prs_sequencer #(
    .PROFILE         (prs_pkg::PRS_PROF_TRIG),
    .CHAIN_SHORT_CYC (SH),
    .CHAIN_LONG_CYC  (LG),
    .RST_SHORT_CYC   (8),
    .RST_LONG_CYC    (RL),
    .FAST_PERIOD_CYC (8),
    .FAST_HIGH_CYC   (4),
    .SLOW_PERIOD_CYC (16),
    .SLOW_HIGH_CYC   (1)
  ) i_prs_sequencer (
    .core_clk_i                (core_clk_i),
    .sys_rst_i                 (sys_rst_i),
    .ce_i                      (ce),
    .pins_i                    (pins),
    .host_i                    (host),
    .rail_pgood_i              (pgood),
    .rail_en_o                 (rail_en),
    .system_reset_out_n_o      (rst_n),
    .pulse_out_3_o             (p3),
    .slow_pulse_outs_o         (slow),
    .dynamic_voltage_scaling_o (dynamic_voltage_scaling),
    .forced_pwm_o              (fpwm)
  );

  prs_rail_model i_prs_rail_model (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .lag_i        (lag),
    .rail_en_i    (rail_en),
    .rail_pgood_o (pgood)
  );

  // Enable profile; its rails report good at once, which is all it needs.
  prs_sequencer #(
    .PROFILE       (prs_pkg::PRS_PROF_EN),
    .RST_SHORT_CYC (8)
  ) i_prs_sequencer_a (
    .core_clk_i                (core_clk_i),
    .sys_rst_i                 (sys_rst_i),
    .ce_i                      (ce),
    .pins_i                    (pins),
    .host_i                    (host),
    .rail_pgood_i              (rail_a),
    .rail_en_o                 (rail_a),
    .system_reset_out_n_o      (rst_a),
    .pulse_out_3_o             (),
    .slow_pulse_outs_o         (),
    .dynamic_voltage_scaling_o (),
    .forced_pwm_o              ()
  );

  // Button profile, started here by the enable rise with the button up.
  prs_sequencer #(
    .PROFILE         (prs_pkg::PRS_PROF_PB),
    .CHAIN_SHORT_CYC (SH),
    .CHAIN_LONG_CYC  (LG),
    .RST_LONG_CYC    (RL)
  ) i_prs_sequencer_c (
    .core_clk_i                (core_clk_i),
    .sys_rst_i                 (sys_rst_i),
    .ce_i                      (ce),
    .pins_i                    (pins),
    .host_i                    (host),
    .rail_pgood_i              (pg_c),
    .rail_en_o                 (rail_c),
    .system_reset_out_n_o      (),
    .pulse_out_3_o             (),
    .slow_pulse_outs_o         (),
    .dynamic_voltage_scaling_o (),
    .forced_pwm_o              (fpwm_c)
  );

  prs_rail_model i_prs_rail_model_c (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .lag_i        (lag),
    .rail_en_i    (rail_c),
    .rail_pgood_o (pg_c)
  );

  // Clock and a free cycle count for measuring gaps.
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;

  // Start delay of the k-th rail of the chain.
  function automatic int dl(input int k);
    return (k == 7) ? LG : (k == 2) ? 0 : SH;
  endfunction : dl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, lo);
    end
  endtask : chk_rng

  // Samples land one step after the edge so updates have settled.
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Main sequence: reset, arming, chain, controls, pulses, shutdown.
  initial begin
    void'($urandom(32'h3cf7));
    lag <= 2'($urandom_range(3, 0));
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    tick(1);
    chk(32'(rail_en), 32'h1000);
    chk(32'({rst_n, p3, slow, fpwm, dynamic_voltage_scaling}), 32'h0);
    chk(32'({fpwm_c, rst_a}), 32'h1E);
    @(posedge core_clk_i);
    pins.sequence_trigger_pin <= 1'b1;
    tick(SH * 4);
    chk(32'(rail_en), 32'h1000);
    @(posedge core_clk_i);
    pins.sequence_trigger_pin <= 1'b0;
    pins.sequence_enable_in   <= 1'b1;
    pins.power_hold_in        <= 1'b1;
    tick(SH * 4);
    chk(32'(rail_en), 32'h1000);
    chk(32'(rail_a), 32'h181F);
    chk(32'(rst_a), 32'h1);
    @(posedge core_clk_i);
    pins.sequence_trigger_pin <= 1'b1;
    #1;
    base  = cyc;
    exp_m = 13'h1000;
    for (int k = 0; k < 8; k++) begin
      n = 0;
      while (rail_en[ORD[k]] !== 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      t[ORD[k]] = cyc;
      exp_m[ORD[k]] = 1'b1;
      chk(32'(rail_en), 32'(exp_m));
      chk_rng(cyc - ((k == 0) ? base : t[ORD[SRC[k]]]),
              dl(k) + 2, dl(k) + 9);
    end
    n = 0;
    while (rst_n !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk_rng(cyc - t[8], RL, RL + 9);
    // Trigger stays high past the settle time before it is dropped.
    tick(SH + 2);
    @(posedge core_clk_i);
    pins.sequence_trigger_pin <= 1'b0;
    tick(10);
    chk(32'(rail_en), 32'(exp_m));
    chk(32'(rail_c), 32'(exp_m));
    // A frozen clock enable holds every rail through an enable drop.
    @(posedge core_clk_i);
    ce                      <= 1'b0;
    pins.sequence_enable_in <= 1'b0;
    tick(4);
    chk(32'(rail_en), 32'(exp_m));
    @(posedge core_clk_i);
    pins.sequence_enable_in <= 1'b1;
    @(posedge core_clk_i);
    ce <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      v = (k == 6) ? 13'h1FFF : 13'($urandom);
      @(posedge core_clk_i);
      host.rail_on <= v;
      tick(3);
      chk(32'(rail_en), 32'(exp_m | (v & 13'h0838)));
      chk(32'(rail_a), 32'(13'h181F | (v & 13'h07E0)));
    end
    @(posedge core_clk_i);
    host.pulse_en <= 4'hF;
    tick(20);
    h3 = 0;
    hs = 0;
    repeat (32) begin
      tick(1);
      h3 += int'(p3);
      hs += int'(slow[0]) + int'(slow[1]) + int'(slow[2]);
    end
    chk_rng(h3, 16, 16);
    chk_rng(hs, 6, 6);
    @(posedge core_clk_i);
    host.pulse_en <= 4'h0;
    tick(4);
    chk(32'({p3, slow}), 32'h0);
    v4 = 4'($urandom);
    @(posedge core_clk_i);
    host.vsel    <= v4;
    host.vsel_we <= 1'b1;
    host.pwm     <= ~v4;
    host.pwm_we  <= 1'b1;
    host.shutdown_resume_enable <= 1'b1;
    @(posedge core_clk_i);
    host.vsel_we <= 1'b0;
    host.pwm_we  <= 1'b0;
    host.vsel    <= ~v4;
    host.pwm     <= v4;
    tick(2);
    chk(32'(dynamic_voltage_scaling), 32'(v4));
    chk(32'(fpwm), 32'(v4 ^ 4'hF));
    @(posedge core_clk_i);
    pins.sequence_enable_in <= 1'b0;
    pins.power_hold_in      <= 1'b0;
    tick(4);
    chk(32'(rail_en), 32'h1000);
    chk(32'(rst_n), 32'h0);
    chk(32'(rail_a), 32'h1800);
    chk(32'(rail_c), 32'h1000);
    summarize();
  end

  // A hang is cut short well beyond the expected run time.
  initial begin
    repeat (3000) @(posedge core_clk_i);
    error_cnt++;
    summarize();
  end
endmodule : prs_sequencer_test
